//--- bench/qdac_host.sv
`timescale 1ns/10ps
// serial host; send runs the link clock inside frames, spin runs it while deselected
module qdac_host
(
    output logic sclk = 1'b0,
    output logic cs_n = 1'b1,
    output logic serial_in = 1'b0
);
    // msb first, cs_n held low across all bits
    task automatic send(input logic [23:0] w, input int n);
        #7 cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            serial_in = w[i];
            #24 sclk = 1'b1;
            #24 sclk = 1'b0;
        end
        #24 cs_n = 1'b1;
        serial_in = ~serial_in; // released line must not keep the last bit
    endtask
    // clock while deselected, to show it is ignored
    task automatic spin(input int n);
        repeat (n)
        begin
            serial_in = 1'($urandom);
            #24 sclk = 1'b1;
            #24 sclk = 1'b0;
        end
    endtask
endmodule

//--- bench/qdac_load_properties.sv
`timescale 1ns/10ps
module qdac_load_properties
#(
    parameter int NUM_CH = qdac_pkg::NUM_CH
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic serial_in,
    input wire logic chain_out,
    input wire logic load_outputs_n,
    input wire logic preset_n,
    input wire logic level_select,
    input wire logic [NUM_CH-1:0][qdac_pkg::DATA_W-1:0] input_regs,
    input wire logic [NUM_CH-1:0][qdac_pkg::DATA_W-1:0] output_regs
);
    logic [3:0]  up_ff;
    logic [4:0]  bits_ff;
    wire  [15:0] pv = level_select ? 16'h8000 : 16'h0000;
    always_ff @(posedge clk or negedge arst_n)
        if (!arst_n) up_ff <= '0;
        else if (up_ff != 4'hf) up_ff <= up_ff + 4'h1;
    // bits seen in the current frame; cs_n high clears it even with the link clock stopped
    always_ff @(posedge sclk or posedge cs_n)
        if (cs_n) bits_ff <= '0;
        else if (bits_ff != 5'h1f) bits_ff <= bits_ff + 5'h1;
    preset_value_a: assert property (@(posedge clk) disable iff (!arst_n)
        (!preset_n)[*7] |-> input_regs == {NUM_CH{pv}} && output_regs == {NUM_CH{pv}}) else $error("preset value");
    power_on_a: assert property (@(posedge clk) disable iff (!arst_n)
        up_ff == 4'hc |-> input_regs == {NUM_CH{pv}} && output_regs == {NUM_CH{pv}}) else $error("power-on value");
    preset_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        (!preset_n)[*8] |-> $stable(input_regs) && $stable(output_regs)) else $error("preset overridden");
    load_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
        (load_outputs_n && preset_n && up_ff == 4'hf)[*8] |-> $stable(output_regs)) else $error("stray copy");
    load_copy_a: assert property (@(posedge clk) disable iff (!arst_n)
        (!load_outputs_n && preset_n && cs_n && up_ff == 4'hf)[*7] |-> output_regs == input_regs) else $error("no copy");
    xfer_cause_a: assert property (@(posedge clk) disable iff (!arst_n)
        $changed(input_regs) && preset_n && up_ff == 4'hf |-> cs_n
        && !($past(cs_n, 3) && $past(cs_n, 4) && $past(cs_n, 5) && $past(cs_n, 6))) else $error("stray transfer");
    chain_delay_a: assert property (@(posedge sclk) disable iff (!arst_n)
        bits_ff >= 5'd20 |-> chain_out == $past(serial_in, 20)) else $error("chain delay");
    shift_hold_a: assert property (@(posedge sclk) disable iff (!arst_n)
        cs_n && $past(cs_n) |-> $stable(chain_out)) else $error("shift while deselected");
endmodule
bind qdac_load qdac_load_properties #(.NUM_CH(NUM_CH)) i_qdac_load_properties (.clk(clk), .arst_n(arst_n),
    .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in), .chain_out(chain_out), .load_outputs_n(load_outputs_n),
    .preset_n(preset_n), .level_select(level_select), .input_regs(input_regs), .output_regs(output_regs));

//--- bench/test_quad_dac_serial_load_logic.sv
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; $display("unexpected at %0t: bad value", $time); end end
module test_quad_dac_serial_load_logic;
    logic clk = 1'b0, arst_n = 1'b0, load_outputs_n = 1'b1, preset_n = 1'b1, level_select = 1'b1;
    logic sclk, cs_n, serial_in, chain_out;
    logic [3:0][15:0] in_regs, out_regs;
    logic [23:0] w;
    int exp_in[4], exp_out[4], failures, total_checks;
    qdac_load i_qdac_load (.clk(clk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in),
        .chain_out(chain_out), .load_outputs_n(load_outputs_n), .preset_n(preset_n),
        .level_select(level_select), .input_regs(in_regs), .output_regs(out_regs));
    qdac_host i_qdac_host (.sclk(sclk), .cs_n(cs_n), .serial_in(serial_in));
    initial
    begin
        forever #20 clk = ~clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check_all();
        for (int c = 0; c < 4; c++)
        begin
            `CHK(in_regs[c], exp_in[c][15:0])
            `CHK(out_regs[c], exp_out[c][15:0])
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        #100000;
        failures++;
        end_of_test();
    end
    initial
    begin
        void'($urandom(80));
        exp_in = '{4{32'h8000}};
        exp_out = exp_in;
        tick(3);
        arst_n = 1'b1;
        tick(20);
        check_all();
        for (int c = 0; c < 8; c++)
        begin
            w = 24'($urandom);
            w[17:16] = 2'(c);
            fork
                i_qdac_host.send(w, c == 5 ? 24 : 18);
                if (c == 6)
                begin
                    tick(2);
                    load_outputs_n = 1'b0;
                    tick(8);
                    load_outputs_n = 1'b1;
                    exp_out = exp_in;
                end
            join
            exp_in[c % 4] = w[15:0];
            tick(8);
            check_all();
            if (c == 5)
                `CHK(chain_out, w[19])
        end
        i_qdac_host.spin(30);
        // a short frame after the idle clocks: its word keeps ten bits of the previous frame
        w = {6'h0, w[9:0], 8'($urandom)};
        i_qdac_host.send(w, 8);
        exp_in[w[17:16]] = w[15:0];
        tick(8);
        check_all();
        load_outputs_n = 1'b0;
        tick(10);
        exp_out = exp_in;
        check_all();
        load_outputs_n = 1'b1;
        for (int lv = 0; lv < 2; lv++)
        begin
            level_select = 1'(lv);
            tick(5);
            preset_n = 1'b0;
            load_outputs_n = 1'b0;
            i_qdac_host.send(24'($urandom), 18);
            tick(8);
            exp_in = '{4{lv ? 32'h8000 : 32'h0000}};
            exp_out = exp_in;
            load_outputs_n = 1'b1;
            preset_n = 1'b1;
            tick(8);
            check_all();
        end
        // second power-on with the level select low
        level_select = 1'b0;
        tick(3);
        arst_n = 1'b0;
        tick(3);
        arst_n = 1'b1;
        tick(20);
        exp_in = '{4{32'h0000}};
        exp_out = exp_in;
        check_all();
        end_of_test();
    end
endmodule

//--- design/qdac_load.sv
`timescale 1ns/10ps
module qdac_load
#(
    parameter int NUM_CH = qdac_pkg::NUM_CH
)
(
    input  wire logic                                 clk,
    input  wire logic                                 arst_n,
    input  wire logic                                 sclk,
    input  wire logic                                 cs_n,
    input  wire logic                                 serial_in,
    output logic                                      chain_out,
    input  wire logic                                 load_outputs_n,
    input  wire logic                                 preset_n,
    input  wire logic                                 level_select,
    output logic [NUM_CH-1:0][qdac_pkg::DATA_W-1:0]   input_regs,
    output logic [NUM_CH-1:0][qdac_pkg::DATA_W-1:0]   output_regs
);

    localparam int SHIFT_W = qdac_pkg::CHAIN_DLY;

    localparam int POR_WAIT = qdac_pkg::SYNC_STAGES + 1;

    if (NUM_CH != 4)
    begin
        $error("qdac_load serves exactly four channels");
    end

    // the power-on counter is three bits wide
    if (POR_WAIT > 7)
    begin
        $error("qdac_load power-on wait does not fit its counter");
    end

    // reset release
    logic [1:0] rst_sync_ff;
    logic [1:0] nxt_rst_sync;
    logic       rst_n;

    always_comb
    begin
        nxt_rst_sync = {rst_sync_ff[0], 1'b1};
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rst_sync_ff <= 2'b00;
        else
            rst_sync_ff <= nxt_rst_sync;
    end

    assign rst_n = rst_sync_ff[1];

    // ---------------- link domain (sclk) ----------------
    // the 19-stage register doubles as the chain delay; the low 18 bits form the word
    logic [SHIFT_W-1:0] shift_ff;
    logic [SHIFT_W-1:0] nxt_shift;
    logic               chain_ff;
    logic               nxt_chain;

    always_comb
    begin
        nxt_shift = shift_ff;
        if (!cs_n)
            nxt_shift = {shift_ff[SHIFT_W-2:0], serial_in};
        nxt_chain = cs_n ? chain_ff : shift_ff[SHIFT_W-1];
    end

    // no reset: sclk may stand still, and the content is meaningless until 18 bits arrive
    always_ff @(posedge sclk)
    begin
        shift_ff <= nxt_shift;
        chain_ff <= nxt_chain;
    end

    // chain_ff sits one edge behind the tail, so a bit entering at edge k leaves after edge k+19
    assign chain_out = chain_ff;

    // snapshot on chip select rising; held stable while cs_n is high, so the clk side
    // may read it after the synchronised edge
    qdac_pkg::qdac_word_t snap_ff;
    qdac_pkg::qdac_word_t nxt_snap;

    always_comb
    begin
        nxt_snap = qdac_pkg::qdac_word_t'(shift_ff[qdac_pkg::WORD_W-1:0]);
    end

    always_ff @(posedge cs_n)
    begin
        snap_ff <= nxt_snap;
    end

    // ---------------- clk domain ----------------
    logic cs_s;
    logic ld_s;
    logic pr_s;
    logic lv_s;

    qdac_sync #(.INIT(1'b1)) u_sync_cs
    (
        .clk  (clk),
        .rst_n(rst_n),
        .din  (cs_n),
        .dout (cs_s)
    );

    qdac_sync #(.INIT(1'b1)) u_sync_ld
    (
        .clk  (clk),
        .rst_n(rst_n),
        .din  (load_outputs_n),
        .dout (ld_s)
    );

    qdac_sync #(.INIT(1'b1)) u_sync_pr
    (
        .clk  (clk),
        .rst_n(rst_n),
        .din  (preset_n),
        .dout (pr_s)
    );

    qdac_sync #(.INIT(1'b0)) u_sync_lv
    (
        .clk  (clk),
        .rst_n(rst_n),
        .din  (level_select),
        .dout (lv_s)
    );

    typedef enum logic [1:0] { QDAC_POR, QDAC_RUN } qdac_state_t;

    qdac_state_t                                 state_ff;
    qdac_state_t                                 nxt_state;
    logic                                        cs_prev_ff;
    logic                                        nxt_cs_prev;
    logic [NUM_CH-1:0][qdac_pkg::DATA_W-1:0]     in_ff;
    logic [NUM_CH-1:0][qdac_pkg::DATA_W-1:0]     nxt_in;
    logic [NUM_CH-1:0][qdac_pkg::DATA_W-1:0]     out_ff;
    logic [NUM_CH-1:0][qdac_pkg::DATA_W-1:0]     nxt_out;
    logic [qdac_pkg::DATA_W-1:0]                 preset_val;
    qdac_pkg::qdac_xfer_t                        xfer;
    logic [1:0]                                  ch_idx;
    logic [2:0]                                  por_cnt_ff;
    logic [2:0]                                  nxt_por_cnt;

    always_comb
    begin
        preset_val = lv_s ? qdac_pkg::HALF_SCALE : qdac_pkg::ZERO_SCALE;
        xfer.valid = cs_s && !cs_prev_ff;
        xfer.word  = snap_ff;
        ch_idx     = {xfer.word.channel_select_hi, xfer.word.channel_select_lo};
        nxt_cs_prev = cs_s;
        nxt_por_cnt = por_cnt_ff;
        nxt_state  = QDAC_RUN;
        nxt_in     = in_ff;
        nxt_out    = out_ff;
        case (state_ff)
            QDAC_POR:
            begin
                // keep loading until the level select synchroniser has settled; leaving on the
                // first edge would always give zero code, whatever the pin says
                nxt_por_cnt = por_cnt_ff + 3'h1;
                if (por_cnt_ff != 3'(POR_WAIT))
                    nxt_state = QDAC_POR;
                for (int i = 0; i < NUM_CH; i++)
                begin
                    nxt_in[i]  = preset_val;
                    nxt_out[i] = preset_val;
                end
            end
            QDAC_RUN:
            begin
                if (!pr_s)
                begin
                    for (int i = 0; i < NUM_CH; i++)
                    begin
                        nxt_in[i]  = preset_val;
                        nxt_out[i] = preset_val;
                    end
                end
                else
                begin
                    if (xfer.valid)
                        nxt_in[ch_idx] = xfer.word.code;
                    if (!ld_s)
                        nxt_out = nxt_in;
                end
            end
            default:
            begin
                nxt_state = QDAC_POR;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff   <= QDAC_POR;
            cs_prev_ff <= 1'b1;
            por_cnt_ff <= 3'h0;
            in_ff      <= '0;
            out_ff     <= '0;
        end
        else
        begin
            state_ff   <= nxt_state;
            cs_prev_ff <= nxt_cs_prev;
            por_cnt_ff <= nxt_por_cnt;
            in_ff      <= nxt_in;
            out_ff     <= nxt_out;
        end
    end

    assign input_regs  = in_ff;
    assign output_regs = out_ff;

endmodule

//--- design/qdac_pkg.sv
package qdac_pkg;

    localparam int          DATA_W      = 16;
    localparam int          WORD_W      = 18;
    localparam int          NUM_CH      = 4;
    localparam int          CHAIN_DLY   = 19;
    localparam int          ADDR_HI_POS = 17;
    localparam int          ADDR_LO_POS = 16;
    localparam logic [15:0] HALF_SCALE  = 16'h8000;
    localparam logic [15:0] ZERO_SCALE  = 16'h0000;
    localparam int          SYNC_STAGES = 3;

    typedef struct packed {
        logic        channel_select_hi;
        logic        channel_select_lo;
        logic [15:0] code;
    } qdac_word_t;

    typedef struct packed {
        logic        valid;
        qdac_word_t  word;
    } qdac_xfer_t;

endpackage

//--- design/qdac_sync.sv
`timescale 1ns/10ps
// three-stage synchroniser; a change counts once stages two and three agree
module qdac_sync
#(
    parameter logic INIT = 1'b1
)
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic din,
    output logic      dout
);

    logic [2:0] sync_ff;
    logic [2:0] nxt_sync;
    logic       dout_ff;
    logic       nxt_dout;

    always_comb
    begin
        nxt_sync = {sync_ff[1:0], din};
        nxt_dout = (sync_ff[2] == sync_ff[1]) ? sync_ff[1] : dout_ff;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync_ff <= {3{INIT}};
            dout_ff <= INIT;
        end
        else
        begin
            sync_ff <= nxt_sync;
            dout_ff <= nxt_dout;
        end
    end

    assign dout = dout_ff;

endmodule
